// File: design/usf_core.sv
// Serial frame transmitter and receiver with a buffered receive path.
`timescale 1ns/1ps
`include "usf_defs.svh"

// ==========================================
// Receive buffer
module usf_fifo #(
    parameter int W     = 12,
    parameter int DEPTH = 16
) (
    // Clock, reset, enable and flush
    input  wire logic         core_clk_i,
    input  wire logic         rst_n_i,
    input  wire logic         ce_i,
    input  wire logic         flush_i,
    // Filling side
    input  wire logic         in_valid_i,
    output logic              in_ready_o,
    input  wire logic [W-1:0] in_data_i,
    // Draining side
    output logic              out_valid_o,
    input  wire logic         out_ready_i,
    output logic [W-1:0]      out_data_o
);
    localparam int AW = $clog2(DEPTH);
    // Whole buffer state, storage included.
    typedef struct packed {
        logic [DEPTH-1:0][W-1:0] mem;
        logic [AW-1:0]           wr;
        logic [AW-1:0]           rd;
        logic [AW:0]             cnt;
    } usf_fifo_st_t;
    usf_fifo_st_t q;    // Registered state.
    usf_fifo_st_t d;    // Next state.
    logic         push; // Accepted write.
    logic         pop;  // Accepted read.

    assign in_ready_o  = (q.cnt != (AW+1)'(DEPTH));
    assign out_valid_o = (q.cnt != '0);
    assign out_data_o  = q.mem[q.rd];
    assign push        = in_valid_i & in_ready_o;
    assign pop         = out_ready_i & out_valid_o;

    // Pointer and count update; flush wins over traffic.
    always_comb begin
        d = q;
        if (push) begin
            d.mem[q.wr] = in_data_i;
            d.wr        = q.wr + AW'(1);
        end
        if (pop) begin
            d.rd = q.rd + AW'(1);
        end
        d.cnt = q.cnt + (AW+1)'(push) - (AW+1)'(pop);
        if (flush_i) begin
            d.wr  = '0;
            d.rd  = '0;
            d.cnt = '0;
        end
    end

    // State register, frozen while the clock enable is low.
    always_ff @(posedge core_clk_i) begin
        if (!rst_n_i) begin
            q <= '0;
        end else if (ce_i) begin
            q <= d;
        end
    end
endmodule // usf_fifo

// ==========================================
// Transceiver top
module usf_core
    import usf_pkg::*;
(
    // Clock, reset, enable
    input  wire logic           core_clk_i,
    input  wire logic           rst_n_i,
    input  wire logic           ce_i,
    // Configuration
    input  wire usf_frame_cfg_t cfg_i,
    input  wire logic           sync_mode_i,
    input  wire logic           sync_master_i,
    input  wire logic           double_speed_i,
    input  wire logic           clock_polarity_sel_i,
    input  wire logic [11:0]    baud_divisor_i,
    input  wire logic           baud_lo_wr_i,
    // Control and interrupt enables
    input  wire logic           tx_enable_bit_i,
    input  wire logic           rx_enable_bit_i,
    input  wire logic           tx_empty_int_en_i,
    input  wire logic           tx_complete_int_en_i,
    input  wire logic           rx_complete_int_en_i,
    input  wire logic           global_int_en_i,
    // Transmit data port
    input  wire logic           tx_data_wr_i,
    input  wire logic [7:0]     tx_data_i,
    input  wire logic           tx_ninth_bit_i,
    input  wire logic           txc_clear_i,
    input  wire logic           txc_int_ack_i,
    // Receive data port
    input  wire logic           rx_data_rd_i,
    output logic [7:0]          rx_data_o,
    output logic                rx_ninth_bit_o,
    output logic                framing_error_flag_o,
    output logic                overrun_flag_o,
    output logic                parity_error_flag_o,
    // Flags and requests
    output logic                tx_buffer_empty_flag_o,
    output logic                tx_complete_flag_o,
    output logic                rx_complete_flag_o,
    output logic                irq_tx_empty_o,
    output logic                irq_tx_complete_o,
    output logic                irq_rx_complete_o,
    // Serial pins
    output logic                txd_o,
    output logic                txd_oe_n_o,
    input  wire logic           rxd_i,
    output logic                rxd_owned_o,
    input  wire logic           serial_clock_pin_i,
    output logic                serial_clock_pin_o,
    output logic                serial_clock_pin_oe_n_o
);
    // Full block state in one record.
    typedef struct packed {
        logic [11:0]  baud_cnt;
        logic         sclk;
        logic         sclk_in;
        logic         sclk_prev;
        logic         sclk_oe_n;
        logic         txd;
        logic         tx_active;
        usf_tx_st_t   tx_st;
        logic [3:0]   tx_os;
        logic [3:0]   tx_bit;
        logic [8:0]   tx_sh;
        logic         tx_par;
        logic [8:0]   txb_data;
        logic         txb_empty;
        logic         tx_complete_flag;
        logic         irq_tx_buffer_empty_flag;
        logic         irq_txc;
        logic         irq_rxc;
        usf_rx_st_t   rx_st;
        logic [3:0]   rx_os;
        logic [2:0]   rx_vote;
        logic [3:0]   rx_bit;
        logic [8:0]   rx_sh;
        logic         rx_par;
        logic         ovr_pend;
        logic         rx_own;
        usf_rx_word_t rx_head;
        logic         rx_complete_flag;
        logic         pop_q;
    } usf_state_t;

    usf_state_t   q;          // Registered state.
    usf_state_t   d;          // Next state.
    logic         tick;       // Baud generator pulse.
    logic [3:0]   os_top;     // Last oversample tick of a bit.
    logic [3:0]   os_mid;     // Centre oversample tick.
    logic         master_run; // Serial clock driven by this end.
    logic         edge_rise;  // Serial clock rising this cycle.
    logic         edge_fall;  // Serial clock falling this cycle.
    logic         tx_step;    // Transmit bit boundary.
    logic         rx_done;    // Receive bit decided.
    logic         rx_bitv;    // Receive bit value.
    logic [3:0]   nb;         // Active data bits.
    logic         par_en;     // Parity enabled.
    logic         par_odd;    // Odd parity selected.
    logic         frame_end;  // Last transmit bit finished.
    logic         push;       // Store a received frame.
    usf_rx_word_t push_word;  // Frame being stored.
    logic         fifo_ready; // Buffer has room.
    logic         fifo_valid; // Buffer holds a frame.
    usf_rx_word_t fifo_word;  // Oldest stored frame.
    logic         pop;        // Software read accepted.

    // ==========================================
    // Baud and serial clock decode
    // Oversample depth sets division.
    assign os_top     = double_speed_i ? `USF_OS_DBL : `USF_OS_NORM;
    assign os_mid     = double_speed_i ? `USF_MID_DBL : `USF_MID_NORM;
    assign tick       = (q.baud_cnt == `USF_BAUD_ZERO);
    assign master_run = sync_mode_i & sync_master_i & (tx_enable_bit_i | rx_enable_bit_i);
    // A master sees its own toggle; a slave sees a registered pin edge.
    assign edge_rise  = sync_master_i ? (tick & ~q.sclk) : (q.sclk_in & ~q.sclk_prev);
    assign edge_fall  = sync_master_i ? (tick & q.sclk) : (~q.sclk_in & q.sclk_prev);
    assign tx_step = sync_mode_i
        ? (clock_polarity_sel_i ? edge_fall : edge_rise)
        : (tick & (q.tx_os == os_top));
    assign rx_done = sync_mode_i
        ? (clock_polarity_sel_i ? edge_rise : edge_fall)
        : (tick & (q.rx_os == os_top));
    assign rx_bitv = sync_mode_i ? rxd_i : usf_major(q.rx_vote);
    assign nb      = usf_nbits(cfg_i.char_size);
    assign par_en  = cfg_i.parity_mode[`USF_PM_EN];
    assign par_odd = cfg_i.parity_mode[`USF_PM_ODD];
    // A software read advances the buffer once; the guard covers the
    // cycle in which the head register still shows the popped frame.
    assign pop     = rx_data_rd_i & q.rx_complete_flag & ~q.pop_q;

    // ==========================================
    // Next-state logic
    always_comb begin
        d         = q;
        frame_end = 1'b0;
        push      = 1'b0;
        push_word = '0;
        // Reload at zero or low-byte write.
        d.baud_cnt = (baud_lo_wr_i | tick) ? baud_divisor_i : q.baud_cnt - 12'h001;
        // Serial clock: master toggles per tick, slave pin is registered.
        d.sclk_in   = serial_clock_pin_i;
        d.sclk_prev = q.sclk_in;
        d.sclk_oe_n = ~master_run;
        if (!master_run) begin
            d.sclk = 1'b0;
        end else if (tick) begin
            d.sclk = ~q.sclk;
        end
        // Transmit oversample counter runs freely between frames.
        if (tick) begin
            d.tx_os = (q.tx_os == os_top) ? `USF_ZERO4 : q.tx_os + `USF_ONE4;
        end
        if (tx_data_wr_i && tx_enable_bit_i && q.txb_empty) begin
            // Ninth bit sampled with the data.
            d.txb_data  = {tx_ninth_bit_i, tx_data_i};
            d.txb_empty = 1'b0;
        end
        case (q.tx_st)
            TX_IDLE: begin
                // Waits for a bit boundary before starting.
            end
            TX_START: begin
                if (tx_step) begin
                    d.tx_st  = TX_DATA;
                    d.tx_bit = `USF_ZERO4;
                end
            end
            TX_DATA: begin
                if (tx_step) begin
                    d.tx_sh  = {1'b0, q.tx_sh[8:1]};
                    d.tx_bit = q.tx_bit + `USF_ONE4;
                    if (q.tx_bit == nb - `USF_ONE4) begin
                        d.tx_st = par_en ? TX_PAR : TX_STOP1;
                    end
                end
            end
            TX_PAR: begin
                if (tx_step) begin
                    d.tx_st = TX_STOP1;
                end
            end
            TX_STOP1: begin
                if (tx_step) begin
                    d.tx_st   = cfg_i.two_stop ? TX_STOP2 : TX_IDLE;
                    frame_end = ~cfg_i.two_stop;
                end
            end
            TX_STOP2: begin
                if (tx_step) begin
                    d.tx_st   = TX_IDLE;
                    frame_end = 1'b1;
                end
            end
            default: begin
                d.tx_st = TX_IDLE;
            end
        endcase
        if (txc_clear_i || txc_int_ack_i) begin
            d.tx_complete_flag = 1'b0;
        end
        // Load shifter when idle or ended.
        if (q.tx_active && !q.txb_empty &&
            (frame_end || (q.tx_st == TX_IDLE && tx_step))) begin
            d.tx_sh     = q.txb_data;
            d.tx_par    = usf_parity(q.txb_data, cfg_i.char_size, par_odd);
            d.txb_empty = 1'b1;
            // Next frame follows with no gap.
            d.tx_st     = TX_START;
        end else if (frame_end) begin
            // Set when nothing waits; set beats clear.
            d.tx_complete_flag = 1'b1;
        end
        // Disable waits for shifter and buffer.
        d.tx_active = tx_enable_bit_i |
                      (q.tx_active & ((d.tx_st != TX_IDLE) | ~d.txb_empty));
        // Start low, stops and idle high.
        case (d.tx_st)
            TX_START: d.txd = 1'b0;
            TX_DATA:  d.txd = d.tx_sh[0];
            TX_PAR:   d.txd = d.tx_par;
            default:  d.txd = `USF_LINE_IDLE;
        endcase
        d.irq_tx_buffer_empty_flag = d.txb_empty & tx_empty_int_en_i & global_int_en_i;
        d.irq_txc  = d.tx_complete_flag & tx_complete_int_en_i & global_int_en_i;
        // Receive oversampling and vote capture around the centre.
        if (tick) begin
            d.rx_os = (q.rx_os == os_top) ? `USF_ZERO4 : q.rx_os + `USF_ONE4;
            if (q.rx_os >= os_mid - `USF_ONE4 && q.rx_os <= os_mid + `USF_ONE4) begin
                d.rx_vote = {q.rx_vote[1:0], rxd_i};
            end
        end
        case (q.rx_st)
            RX_IDLE: begin
                if (sync_mode_i) begin
                    if (rx_done && !rxd_i) begin
                        d.rx_st  = RX_DATA;
                        d.rx_bit = `USF_ZERO4;
                    end
                end else if (!rxd_i) begin
                    d.rx_st   = RX_START;
                    d.rx_os   = `USF_ZERO4;
                    d.rx_vote = '0;
                end
            end
            RX_START: begin
                if (rx_done) begin
                    // A start that went high is noise.
                    d.rx_st  = rx_bitv ? RX_IDLE : RX_DATA;
                    d.rx_bit = `USF_ZERO4;
                end
            end
            RX_DATA: begin
                if (rx_done) begin
                    d.rx_sh  = {rx_bitv, q.rx_sh[8:1]};
                    d.rx_bit = q.rx_bit + `USF_ONE4;
                    if (q.rx_bit == nb - `USF_ONE4) begin
                        d.rx_st = par_en ? RX_PAR : RX_STOP;
                    end
                end
            end
            RX_PAR: begin
                if (rx_done) begin
                    d.rx_par = rx_bitv;
                    d.rx_st  = RX_STOP;
                end
            end
            RX_STOP: begin
                if (rx_done) begin
                    push_word.data    = q.rx_sh >> (4'(`USF_NB_MAX) - nb);
                    push_word.framing = ~rx_bitv;
                    push_word.parity  = par_en &
                        (q.rx_par != usf_parity(push_word.data, cfg_i.char_size, par_odd));
                    push_word.overrun = q.ovr_pend;
                    push              = 1'b1;
                    d.ovr_pend        = ~fifo_ready;
                    d.rx_st           = RX_IDLE;
                end
            end
            default: begin
                d.rx_st = RX_IDLE;
            end
        endcase
        d.rx_own  = rx_enable_bit_i;
        d.rx_complete_flag     = fifo_valid & rx_enable_bit_i & ~pop;
        d.rx_head = fifo_word;
        d.pop_q   = pop;
        if (!rx_enable_bit_i) begin
            d.rx_st    = RX_IDLE;
            d.ovr_pend = 1'b0;
            push       = 1'b0;
        end
        d.irq_rxc = d.rx_complete_flag & rx_complete_int_en_i & global_int_en_i;
    end

    // ==========================================
    // State register
    // Reset holds the line idle and both pins released.
    always_ff @(posedge core_clk_i) begin
        if (!rst_n_i) begin
            q           <= '0;
            q.txd       <= `USF_LINE_IDLE;
            q.txb_empty <= 1'b1;
            q.sclk_oe_n <= 1'b1;
        end else if (ce_i) begin
            q <= d;
        end
    end

    // ==========================================
    // Receive buffer instance
    // A frame finding the buffer full is dropped and marks the next one.
    usf_fifo #(
        .W     ($bits(usf_rx_word_t)),
        .DEPTH (`USF_RX_DEPTH)
    ) u_rx_fifo (
        .core_clk_i  (core_clk_i),
        .rst_n_i     (rst_n_i),
        .ce_i        (ce_i),
        .flush_i     (~rx_enable_bit_i),
        .in_valid_i  (push),
        .in_ready_o  (fifo_ready),
        .in_data_i   (push_word),
        .out_valid_o (fifo_valid),
        .out_ready_i (pop),
        .out_data_o  (fifo_word)
    );

    // ==========================================
    // Outputs, all from state flip-flops
    assign rx_data_o               = q.rx_head.data[7:0];
    assign rx_ninth_bit_o          = q.rx_head.data[8];
    assign framing_error_flag_o    = q.rx_head.framing;
    assign overrun_flag_o          = q.rx_head.overrun;
    assign parity_error_flag_o     = q.rx_head.parity;
    assign tx_buffer_empty_flag_o  = q.txb_empty;
    assign tx_complete_flag_o      = q.tx_complete_flag;
    assign rx_complete_flag_o      = q.rx_complete_flag;
    assign irq_tx_empty_o          = q.irq_tx_buffer_empty_flag;
    assign irq_tx_complete_o       = q.irq_txc;
    assign irq_rx_complete_o       = q.irq_rxc;
    assign txd_o                   = q.txd;
    assign txd_oe_n_o              = ~q.tx_active;
    assign rxd_owned_o             = q.rx_own;
    assign serial_clock_pin_o      = q.sclk;
    assign serial_clock_pin_oe_n_o = q.sclk_oe_n;
endmodule // usf_core

// File: inc/usf_defs.svh
// Constant definitions for the serial frame transceiver.
`ifndef USF_DEFS_SVH
`define USF_DEFS_SVH
// ==========================================
// Frame format codes
`define USF_CS_5      3'h0
`define USF_CS_6      3'h1
`define USF_CS_7      3'h2
`define USF_CS_8      3'h3
`define USF_CS_9      3'h7
`define USF_NB_5      4'h5
`define USF_NB_6      4'h6
`define USF_NB_7      4'h7
`define USF_NB_8      4'h8
`define USF_NB_9      4'h9
`define USF_NB_MAX    9
`define USF_PM_EN     1
`define USF_PM_ODD    0
// ==========================================
// Oversampling and baud timing
`define USF_OS_NORM   4'hF
`define USF_OS_DBL    4'h7
`define USF_MID_NORM  4'h7
`define USF_MID_DBL   4'h3
`define USF_BAUD_W    12
`define USF_BAUD_ZERO 12'h000
// ==========================================
// Receive buffer and reset levels
`define USF_RX_DEPTH  16
`define USF_LINE_IDLE 1'b1
`define USF_ZERO4     4'h0
`define USF_ONE4      4'h1
`endif

// File: inc/usf_pkg.sv
// Types and shared decode functions for the serial frame transceiver.
`include "usf_defs.svh"
package usf_pkg;
    // ==========================================
    // State encodings
    typedef enum logic [2:0] {
        TX_IDLE  = 3'h0,
        TX_START = 3'h1,
        TX_DATA  = 3'h2,
        TX_PAR   = 3'h3,
        TX_STOP1 = 3'h4,
        TX_STOP2 = 3'h5
    } usf_tx_st_t;
    typedef enum logic [2:0] {
        RX_IDLE  = 3'h0,
        RX_START = 3'h1,
        RX_DATA  = 3'h2,
        RX_PAR   = 3'h3,
        RX_STOP  = 3'h4
    } usf_rx_st_t;
    // ==========================================
    // Carriers
    // Frame format shared by both directions.
    typedef struct packed {
        logic [2:0] char_size;
        logic [1:0] parity_mode;
        logic       two_stop;
    } usf_frame_cfg_t;
    // One received frame with its status, stored as a unit.
    typedef struct packed {
        logic       overrun;
        logic       framing;
        logic       parity;
        logic [8:0] data;
    } usf_rx_word_t;
    // ==========================================
    // Decode functions
    // Number of data bits for a size code; unlisted codes act as 8.
    function automatic logic [3:0] usf_nbits(input logic [2:0] cs);
        case (cs)
            `USF_CS_5: usf_nbits = `USF_NB_5;
            `USF_CS_6: usf_nbits = `USF_NB_6;
            `USF_CS_7: usf_nbits = `USF_NB_7;
            `USF_CS_9: usf_nbits = `USF_NB_9;
            default:   usf_nbits = `USF_NB_8;
        endcase
    endfunction
    // Even parity of the active data bits, inverted for odd.
    function automatic logic usf_parity(input logic [8:0] d, input logic [2:0] cs,
                                        input logic odd);
        logic p;
        p = odd;
        for (int i = 0; i < `USF_NB_MAX; i++) begin
            if (4'(i) < usf_nbits(cs)) begin
                p = p ^ d[i];
            end
        end
        usf_parity = p;
    endfunction
    // Two of three votes.
    function automatic logic usf_major(input logic [2:0] v);
        usf_major = (v[0] & v[1]) | (v[0] & v[2]) | (v[1] & v[2]);
    endfunction
endpackage

// File: bench/usf_core_assertions.sv
// Port-level checks for the serial frame transceiver, bound into it.
`timescale 1ns/1ps
module usf_core_chk (
    // Clock, reset and controls
    input wire logic core_clk_i,
    input wire logic rst_n_i,
    input wire logic ce_i,
    input wire logic sync_mode_i,
    input wire logic tx_data_wr_i,
    input wire logic tx_enable_bit_i,
    input wire logic rx_enable_bit_i,
    input wire logic rx_data_rd_i,
    input wire logic tx_empty_int_en_i,
    input wire logic tx_complete_int_en_i,
    input wire logic rx_complete_int_en_i,
    input wire logic global_int_en_i,
    // Flags, requests and pins
    input wire logic tx_buffer_empty_flag_o,
    input wire logic tx_complete_flag_o,
    input wire logic rx_complete_flag_o,
    input wire logic irq_tx_empty_o,
    input wire logic irq_tx_complete_o,
    input wire logic irq_rx_complete_o,
    input wire logic framing_error_flag_o,
    input wire logic parity_error_flag_o,
    input wire logic txd_o,
    input wire logic txd_oe_n_o,
    input wire logic rxd_owned_o
);
    // ==========================================
    // Single clock domain, so clock and reset are stated once.
    default clocking cb @(posedge core_clk_i);
    endclocking
    default disable iff (!rst_n_i);
    a_write_clears: assert property (ce_i && tx_data_wr_i && tx_enable_bit_i
        && tx_buffer_empty_flag_o |=> !tx_buffer_empty_flag_o && !txd_oe_n_o)
        else $error("empty flag or pin ownership wrong after a write");
    a_pin_held: assert property (!tx_buffer_empty_flag_o |-> !txd_oe_n_o)
        else $error("output pin released with data waiting");
    a_empty_irq: assert property (1 |=> irq_tx_empty_o ==
        (tx_buffer_empty_flag_o & $past(tx_empty_int_en_i & global_int_en_i)))
        else $error("empty request does not follow flag and enables");
    a_rx_irq: assert property (1 |=> irq_rx_complete_o ==
        (rx_complete_flag_o & $past(rx_complete_int_en_i & global_int_en_i)))
        else $error("receive request does not follow flag and enables");
    a_txc_irq: assert property ($rose(tx_complete_flag_o) && tx_complete_int_en_i
        && global_int_en_i |=> irq_tx_complete_o)
        else $error("complete request missing");
    a_txc_idle: assert property ($rose(tx_complete_flag_o) |-> txd_o
        && tx_buffer_empty_flag_o) else $error("complete set while busy");
    // Asynchronous bit times are always eight cycles or longer.
    a_start_low: assert property (!sync_mode_i && $fell(txd_o) |-> !txd_o [*8])
        else $error("start bit not held low");
    a_rx_flush: assert property (!rx_enable_bit_i |=> !rx_complete_flag_o)
        else $error("receive flag kept while disabled");
    a_rx_read: assert property (rx_data_rd_i && rx_complete_flag_o
        |=> !rx_complete_flag_o) else $error("read did not drop receive flag");
    a_rx_owns: assert property (rx_enable_bit_i ##1 rx_enable_bit_i |-> rxd_owned_o)
        else $error("receiver does not own input pin");
    c_tx_done: cover property ($rose(tx_complete_flag_o));
    c_rx_done: cover property ($rose(rx_complete_flag_o));
    c_rx_bad: cover property (framing_error_flag_o && parity_error_flag_o);
endmodule // usf_core_chk
bind usf_core usf_core_chk u_usf_core_chk (.*);

// File: bench/usf_remote.sv
// Remote serial end: captures frames from the output line, sends on input.
`timescale 1ns/1ps
module usf_remote (
    // Clock and serial lines
    input  wire logic clk_i,
    input  wire logic txd_i,
    output logic      rxd_o
);
    localparam int BT = 16;  // Bit time at divisor zero, normal speed.
    logic [10:0] cap_q;      // Last captured frame, start bit in bit 0.
    // ==========================================
    // Capture: eleven mid-bit samples; stops short so a next start is seen.
    // sample line order
    initial begin
        rxd_o = 1'b1;
        cap_q = 11'h000;
        forever begin
            @(negedge txd_i);
            repeat (BT / 2) @(posedge clk_i);
            for (int i = 0; i < 11; i++) begin
                cap_q[i] = txd_i;
                if (i < 10) repeat (BT) @(posedge clk_i);
            end
        end
    end
    task automatic send(input logic [11:0] b);
        for (int i = 0; i < 12; i++) begin
            rxd_o <= b[i];
            repeat (BT) @(posedge clk_i);
        end
    endtask
endmodule // usf_remote

// File: bench/tb_usf_core.sv
// Self-checking bench for the serial frame transceiver.
`timescale 1ns/1ps
module tb_usf_core;
    import usf_pkg::*;
    // ==========================================
    // Signals carry the port names so the instance connects by name.
    logic core_clk_i, rst_n_i, ce_i, sync_mode_i, sync_master_i, double_speed_i;
    logic clock_polarity_sel_i, baud_lo_wr_i, tx_enable_bit_i, rx_enable_bit_i;
    logic tx_empty_int_en_i, tx_complete_int_en_i, rx_complete_int_en_i, global_int_en_i;
    logic tx_data_wr_i, tx_ninth_bit_i, txc_clear_i, txc_int_ack_i, rx_data_rd_i, rxd_i;
    logic serial_clock_pin_i, rx_ninth_bit_o, framing_error_flag_o, overrun_flag_o;
    logic parity_error_flag_o, tx_buffer_empty_flag_o, tx_complete_flag_o;
    logic rx_complete_flag_o, irq_tx_empty_o, irq_tx_complete_o, irq_rx_complete_o;
    logic txd_o, txd_oe_n_o, rxd_owned_o, serial_clock_pin_o, serial_clock_pin_oe_n_o;
    logic [11:0]    baud_divisor_i;
    logic [7:0]     tx_data_i, rx_data_o;
    usf_frame_cfg_t cfg_i;
    int n_errors = 0;
    int cmp_count = 0;
    usf_core u_usf_core (.*);
    usf_remote u_usf_remote (.clk_i(core_clk_i), .txd_i(txd_o), .rxd_o(rxd_i));
    initial begin
        core_clk_i = 1'b0;
        forever #50 core_clk_i = ~core_clk_i;
    end
    task automatic tk(input int k);
        repeat (k) @(posedge core_clk_i);
    endtask
    task automatic chk(input logic [11:0] got, input logic [11:0] exp);
        cmp_count++;
        if (got !== exp) begin
            n_errors++;
            $display("[ERR] %0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic print_verdict();
        $display("compares %0d errors %0d", cmp_count, n_errors);
        if (n_errors == 0 && cmp_count > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask
    // Sends one frame, or two back to back while disabling, then checks.
    task automatic t_tx(input usf_frame_cfg_t c, input logic [8:0] d,
                        input logic [10:0] e, input logic b2b);
        @(posedge core_clk_i);
        cfg_i <= c;
        {tx_ninth_bit_i, tx_data_i} <= d;
        {tx_enable_bit_i, tx_data_wr_i, txc_clear_i} <= 3'h7;
        @(posedge core_clk_i);
        {tx_data_wr_i, txc_clear_i} <= 2'h0;
        if (b2b) begin
            @(negedge core_clk_i);
            for (int n = 0; n < 500 && tx_buffer_empty_flag_o !== 1'b1; n++) @(negedge core_clk_i);
            @(posedge core_clk_i);
            tx_data_wr_i <= 1'b1;
            @(posedge core_clk_i);
            tx_data_wr_i <= 1'b0;
        end
        tx_enable_bit_i <= 1'b0;
        #1 chk(tx_buffer_empty_flag_o, 1'b0);
        for (int n = 0; n < 999 && tx_complete_flag_o !== 1'b1; n++) @(negedge core_clk_i);
        tk(48);
        @(negedge core_clk_i);
        chk(u_usf_remote.cap_q, e);
        chk({irq_tx_complete_o, txd_oe_n_o, txd_o}, 3'h7);
        @(posedge core_clk_i);
        txc_int_ack_i <= 1'b1;
        @(posedge core_clk_i);
        txc_int_ack_i <= 1'b0;
        @(negedge core_clk_i);
        chk(tx_complete_flag_o, 1'b0);
    endtask
    // Receives a clean and a faulty frame, reads the first, masks, then flushes.
    task automatic t_rx();
        @(posedge core_clk_i);
        cfg_i <= 6'h1D;
        {rx_enable_bit_i, tx_empty_int_en_i, clock_polarity_sel_i} <= 3'h5;
        tk(2);
        u_usf_remote.send({2'h3, 1'b0, 8'h5A, 1'b0});
        u_usf_remote.send({2'h2, 1'b0, 8'h01, 1'b0});
        tk(2);
        @(negedge core_clk_i);
        chk({rxd_owned_o, rx_complete_flag_o, irq_rx_complete_o}, 3'h7);
        chk({overrun_flag_o, framing_error_flag_o, parity_error_flag_o, rx_data_o}, 11'h05A);
        @(posedge core_clk_i);
        rx_data_rd_i <= 1'b1;
        @(posedge core_clk_i);
        rx_data_rd_i <= 1'b0;
        tk(2);
        @(negedge core_clk_i);
        chk({framing_error_flag_o, parity_error_flag_o, rx_data_o}, 10'h301);
        @(posedge core_clk_i);
        global_int_en_i <= 1'b0;
        tk(2);
        @(negedge core_clk_i);
        chk(irq_rx_complete_o, 1'b0);
        @(posedge core_clk_i);
        rx_enable_bit_i <= 1'b0;
        tk(2);
        @(negedge core_clk_i);
        chk(rx_complete_flag_o, 1'b0);
    endtask
    initial begin
        {ce_i, global_int_en_i, tx_complete_int_en_i, rx_complete_int_en_i} = 4'hF;
        {sync_mode_i, sync_master_i, double_speed_i, serial_clock_pin_i} = 4'h0;
        {clock_polarity_sel_i, baud_lo_wr_i, tx_enable_bit_i, rx_enable_bit_i} = 4'h0;
        {tx_empty_int_en_i, tx_data_wr_i, tx_ninth_bit_i, txc_clear_i} = 4'h8;
        {txc_int_ack_i, rx_data_rd_i, rst_n_i, cfg_i} = 9'h000;
        {baud_divisor_i, tx_data_i} = 20'h00000;
        tk(6);
        rst_n_i <= 1'b1;
        baud_lo_wr_i <= 1'b1;
        tk(1);
        baud_lo_wr_i <= 1'b0;
        t_tx(6'h1C, 9'h007, {2'h3, 8'h07, 1'b0}, 1'b1);
        t_tx(6'h38, 9'h1A5, {1'b1, 9'h1A5, 1'b0}, 1'b1);
        t_tx(6'h07, 9'h013, {4'hF, 1'b0, 5'h13, 1'b0}, 1'b0);
        t_rx();
        print_verdict();
    end
    // Watchdog well beyond the fewer than two thousand cycles the tests need.
    initial begin
        tk(6000);
        n_errors++;
        print_verdict();
    end
endmodule // tb_usf_core
